// *** fwsr_pkg.sv ***
// Purpose: Shared constants and types for the flash status polling host.
// Assumes: 10 MHz clock, byte-wide flash with 18 address bits.
// Notes: Register offsets are byte addresses on a 32-bit Wishbone slave.
package fwsr_pkg;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 8;
    localparam int CLK_MHZ = 10;
    // Strobe phase length of one flash bus cycle, in ns and in cycles.
    localparam int STROBE_NS = 200;
    localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
    // Command sequence addresses and data.
    localparam logic [17:0] UNLOCK1_ADDR = 18'h00555;
    localparam logic [17:0] UNLOCK2_ADDR = 18'h002aa;
    localparam logic [7:0] UNLOCK1_DATA = 8'haa;
    localparam logic [7:0] UNLOCK2_DATA = 8'h55;
    localparam logic [7:0] CMD_PROGRAM = 8'ha0;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
    localparam logic [7:0] CMD_AUTOSELECT = 8'h90;
    localparam logic [7:0] CMD_RESET = 8'hf0;
    localparam logic [7:0] CMD_SUSPEND = 8'hb0;
    localparam logic [7:0] CMD_RESUME = 8'h30;
    // Status bit positions in the data byte.
    localparam int POLL_BIT = 7;
    localparam int TOGGLE1_BIT = 6;
    localparam int TIMEOUT_BIT = 5;
    localparam int ERASE_TMR_BIT = 3;
    localparam int TOGGLE2_BIT = 2;
    // Register byte offsets.
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h4;
    localparam logic [3:0] REG_DATA = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hc;
    // Operation codes written to the control register.
    typedef enum logic [2:0] {
        FWSR_OP_READ = 3'h0,
        FWSR_OP_PROGRAM = 3'h1,
        FWSR_OP_SECTOR_ERASE = 3'h2,
        FWSR_OP_CHIP_ERASE = 3'h3,
        FWSR_OP_AUTOSELECT = 3'h4,
        FWSR_OP_RESET = 3'h5,
        FWSR_OP_SUSPEND = 3'h6,
        FWSR_OP_RESUME = 3'h7
    } fwsr_op_t;
    // Outcome codes in the status register.
    typedef enum logic [1:0] {
        FWSR_RES_NONE = 2'h0,
        FWSR_RES_OK = 2'h1,
        FWSR_RES_FAIL = 2'h2
    } fwsr_res_t;
endpackage : fwsr_pkg

// *** fwsr_cyc_if.sv ***
// Purpose: Carries one flash bus cycle request from sequencer to pin engine.
// Assumes: Single clock domain.
// Notes: req is held until done pulses.
`timescale 1ns/100ps
interface fwsr_cyc_if;
    logic req;
    logic wr;
    logic [17:0] addr;
    logic [7:0] wdata;
    logic done;
    logic [7:0] rdata;
    modport seq (output req, output wr, output addr, output wdata,
        input done, input rdata);
    modport eng (input req, input wr, input addr, input wdata,
        output done, output rdata);
endinterface : fwsr_cyc_if

// *** fwsr_pin_eng.sv ***
// Purpose: Runs one flash read or write cycle on the pins.
// Assumes: Flash data input is asynchronous and is synchronised here.
// Notes: Read data is sampled after two synchroniser stages settle.
`timescale 1ns/100ps
module fwsr_pin_eng (
    input wire logic clk,
    input wire logic rst_n,
    fwsr_cyc_if.eng cyc,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic [17:0] flash_addr,
    output logic [7:0] flash_dq_o,
    output logic flash_dq_oe,
    input wire logic [7:0] flash_dq_i
);
    logic [3:0] cnt;
    logic busy;
    logic [7:0] dq_s1;
    logic [7:0] dq_s2;
    logic [7:0] rdata;
    logic done;

    localparam logic [3:0] STROBE_LAST = fwsr_pkg::STROBE_CNT + 4'h2;

    always_ff @(posedge clk) begin
        dq_s1 <= flash_dq_i;
        dq_s2 <= dq_s1;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy <= 1'b0;
            cnt <= 4'h0;
            done <= 1'b0;
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
            flash_dq_oe <= 1'b0;
            flash_addr <= '0;
            flash_dq_o <= '0;
            rdata <= '0;
        end else begin
            done <= 1'b0;
            if (!busy && cyc.req && !done) begin
                busy <= 1'b1;
                cnt <= 4'h0;
                flash_addr <= cyc.addr;
                flash_dq_o <= cyc.wdata;
                flash_dq_oe <= cyc.wr;
                flash_ce_n <= 1'b0;
                flash_we_n <= !cyc.wr;
                flash_oe_n <= cyc.wr;
            end else if (busy) begin
                cnt <= cnt + 4'h1;
                if (cnt == STROBE_LAST) begin
                    rdata <= dq_s2;
                    flash_ce_n <= 1'b1;
                    flash_oe_n <= 1'b1;
                    flash_we_n <= 1'b1;
                end
                if (cnt == STROBE_LAST + 4'h1) begin
                    flash_dq_oe <= 1'b0;
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end

    assign cyc.done = done;
    assign cyc.rdata = rdata;

    strobe_pair_a: assert property (@(posedge clk) disable iff (!rst_n)
        !(flash_we_n == 1'b0 && flash_oe_n == 1'b0))
        else $error("write and output strobes both active");
endmodule : fwsr_pin_eng

// *** fwsr_seq_rom.sv ***
// Purpose: Maps an operation and a step number onto one flash bus cycle.
// Assumes: Purely combinational lookup.
// Notes: last marks the final cycle of a sequence.
`timescale 1ns/100ps
module fwsr_seq_rom (
    input wire logic [2:0] op,
    input wire logic [2:0] step,
    input wire logic [17:0] user_addr,
    input wire logic [7:0] user_data,
    output logic wr,
    output logic [17:0] addr,
    output logic [7:0] data,
    output logic last
);
    always_comb begin
        wr = 1'b1;
        addr = fwsr_pkg::UNLOCK1_ADDR;
        data = fwsr_pkg::UNLOCK1_DATA;
        last = 1'b0;
        if (step == 3'h1 || step == 3'h4) begin
            addr = fwsr_pkg::UNLOCK2_ADDR;
            data = fwsr_pkg::UNLOCK2_DATA;
        end
        unique case (fwsr_pkg::fwsr_op_t'(op))
            fwsr_pkg::FWSR_OP_READ: begin
                wr = 1'b0;
                addr = user_addr;
                last = 1'b1;
            end
            fwsr_pkg::FWSR_OP_RESET,
            fwsr_pkg::FWSR_OP_SUSPEND,
            fwsr_pkg::FWSR_OP_RESUME: begin
                data = (op == 3'(fwsr_pkg::FWSR_OP_RESET)) ?
                    fwsr_pkg::CMD_RESET :
                    (op == 3'(fwsr_pkg::FWSR_OP_SUSPEND)) ?
                    fwsr_pkg::CMD_SUSPEND : fwsr_pkg::CMD_RESUME;
                last = 1'b1;
            end
            fwsr_pkg::FWSR_OP_PROGRAM: begin
                if (step == 3'h2) begin
                    data = fwsr_pkg::CMD_PROGRAM;
                end else if (step == 3'h3) begin
                    addr = user_addr;
                    data = user_data;
                    last = 1'b1;
                end
            end
            fwsr_pkg::FWSR_OP_AUTOSELECT: begin
                if (step == 3'h2) begin
                    data = fwsr_pkg::CMD_AUTOSELECT;
                end else if (step == 3'h3) begin
                    wr = 1'b0;
                    addr = user_addr;
                    last = 1'b1;
                end
            end
            default: begin
                if (step == 3'h2) begin
                    data = fwsr_pkg::CMD_ERASE_SETUP;
                end else if (step == 3'h5) begin
                    last = 1'b1;
                    if (op == 3'(fwsr_pkg::FWSR_OP_CHIP_ERASE)) begin
                        data = fwsr_pkg::CMD_CHIP_ERASE;
                    end else begin
                        addr = user_addr;
                        data = fwsr_pkg::CMD_SECTOR_ERASE;
                    end
                end
            end
        endcase
    end
endmodule : fwsr_seq_rom

// *** fwsr_host.sv ***
// Purpose: Host controller issuing flash commands and polling their status.
// Assumes: Classic Wishbone slave for software, flash pins on the far side.
// Notes: Status polling uses the toggle bit algorithm on a valid address.
//
// Overview of operation
// - Command sequence cycles are writes, except reads.
// - Reset command leaves autoselect or failed status.
// - Autoselect sequence ends with a read cycle.
// - Poll at programmed address or erasing sector.
// - Take data only from later reads.
// - Two consecutive reads compare the toggle bit.
// - Toggling with timeout bit: recheck, then reset.
// - Interrupted polling restarts from the first step.
//
// Implementation choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/100ps
module fwsr_host (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic [17:0] flash_addr,
    output logic [7:0] flash_dq_o,
    output logic flash_dq_oe,
    input wire logic [7:0] flash_dq_i
);
    typedef enum logic [2:0] {
        FWSR_IDLE = 3'b000,
        FWSR_CMD = 3'b001,
        FWSR_POLL1 = 3'b011,
        FWSR_POLL2 = 3'b010,
        FWSR_RECHK = 3'b110,
        FWSR_RST = 3'b111,
        FWSR_FIN = 3'b101
    } fwsr_state_t;

    fwsr_state_t state;
    fwsr_cyc_if cyc ();
    logic [2:0] op;
    logic [17:0] op_addr;
    logic [7:0] op_data;
    logic [2:0] step;
    logic [7:0] first_rd;
    logic [7:0] last_rd;
    logic [1:0] result;
    logic rom_wr;
    logic [17:0] rom_addr;
    logic [7:0] rom_data;
    logic rom_last;
    logic toggling;
    logic busy;
    logic wb_hit;

    fwsr_seq_rom u_rom (
        .op(op),
        .step(step),
        .user_addr(op_addr),
        .user_data(op_data),
        .wr(rom_wr),
        .addr(rom_addr),
        .data(rom_data),
        .last(rom_last)
    );

    fwsr_pin_eng u_eng (
        .clk(clk),
        .rst_n(rst_n),
        .cyc(cyc.eng),
        .flash_ce_n(flash_ce_n),
        .flash_oe_n(flash_oe_n),
        .flash_we_n(flash_we_n),
        .flash_addr(flash_addr),
        .flash_dq_o(flash_dq_o),
        .flash_dq_oe(flash_dq_oe),
        .flash_dq_i(flash_dq_i)
    );

    assign busy = (state != FWSR_IDLE);
    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign toggling = (cyc.rdata[fwsr_pkg::TOGGLE1_BIT] !=
        last_rd[fwsr_pkg::TOGGLE1_BIT]);

    // Wishbone slave: one wait state, ack drops the cycle after.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_hit;
            if (wb_hit && !wb_we_i) begin
                unique case (wb_adr_i[3:0])
                    fwsr_pkg::REG_CTRL: wb_dat_o <= {29'h0, op};
                    fwsr_pkg::REG_ADDR: wb_dat_o <= {14'h0, op_addr};
                    fwsr_pkg::REG_DATA: wb_dat_o <= {24'h0, first_rd};
                    fwsr_pkg::REG_STATUS:
                        wb_dat_o <= {21'h0, last_rd, result, busy};
                    default: wb_dat_o <= '0;
                endcase
            end
        end
    end

    // Register writes; a write to the control register starts an operation.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            op <= 3'h0;
            op_addr <= '0;
            op_data <= '0;
        end else if (wb_hit && wb_we_i && !busy && wb_sel_i[0]) begin
            if (wb_adr_i[3:0] == fwsr_pkg::REG_CTRL) begin
                op <= wb_dat_i[2:0];
            end
            if (wb_adr_i[3:0] == fwsr_pkg::REG_ADDR) begin
                op_addr <= wb_dat_i[17:0];
            end
            if (wb_adr_i[3:0] == fwsr_pkg::REG_DATA) begin
                op_data <= wb_dat_i[7:0];
            end
        end
    end

    logic start;
    assign start = wb_hit && wb_we_i && !busy && wb_sel_i[0] &&
        (wb_adr_i[3:0] == fwsr_pkg::REG_CTRL);

    // Cycle request toward the pin engine.
    always_comb begin
        cyc.req = 1'b0;
        cyc.wr = rom_wr;
        cyc.addr = rom_addr;
        cyc.wdata = rom_data;
        unique case (state)
            FWSR_CMD: cyc.req = 1'b1;
            FWSR_RST: begin
                cyc.req = 1'b1;
                cyc.wr = 1'b1;
                cyc.wdata = fwsr_pkg::CMD_RESET;
            end
            FWSR_POLL1, FWSR_POLL2, FWSR_RECHK: begin
                cyc.req = 1'b1;
                cyc.wr = 1'b0;
                cyc.addr = op_addr;
            end
            default: cyc.req = 1'b0;
        endcase
    end

    // Operation sequencer with toggle bit polling.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= FWSR_IDLE;
            step <= 3'h0;
            result <= 2'(fwsr_pkg::FWSR_RES_NONE);
            first_rd <= '0;
            last_rd <= '0;
        end else begin
            unique case (state)
                FWSR_IDLE: begin
                    if (start) begin
                        step <= 3'h0;
                        result <= 2'(fwsr_pkg::FWSR_RES_NONE);
                        state <= FWSR_CMD;
                    end
                end
                FWSR_CMD: begin
                    if (cyc.done) begin
                        step <= step + 3'h1;
                        if (rom_last) begin
                            first_rd <= cyc.rdata;
                            // Program, erase and resume start fresh polling.
                            if (op == 3'(fwsr_pkg::FWSR_OP_PROGRAM) ||
                                op == 3'(fwsr_pkg::FWSR_OP_SECTOR_ERASE) ||
                                op == 3'(fwsr_pkg::FWSR_OP_CHIP_ERASE) ||
                                op == 3'(fwsr_pkg::FWSR_OP_RESUME)) begin
                                state <= FWSR_POLL1;
                            end else begin
                                state <= FWSR_FIN;
                            end
                        end
                    end
                end
                FWSR_POLL1: begin
                    if (cyc.done) begin
                        last_rd <= cyc.rdata;
                        state <= FWSR_POLL2;
                    end
                end
                FWSR_POLL2: begin
                    if (cyc.done) begin
                        last_rd <= cyc.rdata;
                        if (!toggling) begin
                            state <= FWSR_RECHK;
                        end else if (cyc.rdata[fwsr_pkg::TIMEOUT_BIT]) begin
                            state <= FWSR_RECHK;
                            result <= 2'(fwsr_pkg::FWSR_RES_FAIL);
                        end
                    end
                end
                FWSR_RECHK: begin
                    if (cyc.done) begin
                        if (toggling) begin
                            state <= FWSR_RST;
                        end else begin
                            first_rd <= cyc.rdata;
                            result <= 2'(fwsr_pkg::FWSR_RES_OK);
                            state <= FWSR_FIN;
                        end
                        last_rd <= cyc.rdata;
                    end
                end
                FWSR_RST: begin
                    if (cyc.done) begin
                        result <= 2'(fwsr_pkg::FWSR_RES_FAIL);
                        state <= FWSR_FIN;
                    end
                end
                FWSR_FIN: begin
                    if (result == 2'(fwsr_pkg::FWSR_RES_NONE)) begin
                        result <= 2'(fwsr_pkg::FWSR_RES_OK);
                    end
                    state <= FWSR_IDLE;
                end
                default: state <= FWSR_IDLE;
            endcase
        end
    end

    sequence fwsr_toggle_fail_s;
        state == FWSR_RECHK && cyc.done && toggling;
    endsequence

    recheck_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
        fwsr_toggle_fail_s |=> state == FWSR_RST)
        else $error("toggling after recheck did not issue reset");

    reset_data_a: assert property (@(posedge clk) disable iff (!rst_n)
        state == FWSR_RST && !flash_we_n |->
        flash_dq_oe && flash_dq_o == fwsr_pkg::CMD_RESET)
        else $error("reset cycle carries wrong data");

    poll_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        state inside {FWSR_POLL1, FWSR_POLL2, FWSR_RECHK} && !flash_ce_n |->
        flash_we_n && !flash_oe_n && flash_addr == op_addr)
        else $error("poll is not a read at the operation address");

    poll_pair_a: assert property (@(posedge clk) disable iff (!rst_n)
        state == FWSR_POLL1 && cyc.done |=> state == FWSR_POLL2)
        else $error("first poll read not followed by second");

    ok_stable_a: assert property (@(posedge clk) disable iff (!rst_n)
        state == FWSR_RECHK && cyc.done && !toggling |=>
        result == 2'(fwsr_pkg::FWSR_RES_OK))
        else $error("finished operation not reported ok");

    ack_once_a: assert property (@(posedge clk) disable iff (!rst_n)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    cmd_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        state == FWSR_CMD && step < 3'h3 && !flash_ce_n &&
        op != 3'(fwsr_pkg::FWSR_OP_READ) |-> !flash_we_n && flash_oe_n)
        else $error("unlock cycle not a write");

    sequence fwsr_busy_write_s;
        busy && wb_hit && wb_we_i;
    endsequence

    busy_refuse_a: assert property (@(posedge clk) disable iff (!rst_n)
        fwsr_busy_write_s |=> $stable(op_addr) && $stable(op))
        else $error("register changed during an operation");

    prog_poll_a: assert property (@(posedge clk) disable iff (!rst_n)
        state == FWSR_CMD && cyc.done && rom_last &&
        op == 3'(fwsr_pkg::FWSR_OP_PROGRAM) |=>
        state == FWSR_POLL1)
        else $error("program not followed by fresh polling");

    fail_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
        state == FWSR_RST && cyc.done |=>
        state == FWSR_FIN && result == 2'(fwsr_pkg::FWSR_RES_FAIL))
        else $error("reset command did not end in failure");

    fail_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        state == FWSR_POLL2 && cyc.done && toggling &&
        cyc.rdata[fwsr_pkg::TIMEOUT_BIT] |=>
        result == 2'(fwsr_pkg::FWSR_RES_FAIL))
        else $error("timeout bit not recorded as failure");
endmodule : fwsr_host

// *** fwsr_flash_model.sv ***
// Purpose: Behavioural byte-wide flash that answers the host's strobes.
// Assumes: Sector is address bits 17:13 and sector PROT_SEC is protected.
// Notes: Writes act as the write strobe ends; toggles flip as reads end.
`timescale 1ns/100ps
module fwsr_flash_model #(
    parameter int PROT_SEC = 1,
    parameter int PROG_NS = 3000,
    parameter int ERASE_NS = 20000,
    // Arbitrary identity value returned on other autoselect reads.
    parameter logic [7:0] ID_CODE = 8'h5a
) (
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [17:0] addr,
    input wire logic [7:0] dq_in,
    output logic [7:0] dq_out,
    output logic dq_en
);
    logic [7:0] mem [int];
    logic [17:0] a_lat = '0;
    logic [17:0] tgt = '0;
    logic [7:0] d_lat = '0;
    logic [7:0] pd = '0;
    int step, gen, n_wr, bad_poll;
    bit busy, erasing, chip, auto, fail, fail_next, tg1, tg2, susp;
    wire wcyc = !ce_n && !we_n;
    wire rcyc = !ce_n && !oe_n;

    function automatic logic [7:0] rd(input logic [17:0] a);
        return mem.exists(a) ? mem[a] : 8'hff;
    endfunction : rd

    function automatic logic prot(input logic [17:0] a);
        return a[17:13] == 5'(PROT_SEC);
    endfunction : prot

    function automatic logic in_sec(input logic [17:0] a);
        return chip ? !prot(a) : a[17:13] == tgt[17:13];
    endfunction : in_sec

    task automatic start(input bit er, input bit ch, input int ns);
        int g;
        gen++;
        g = gen;
        {busy, erasing, chip, fail, fail_next} = {1'b1, er, ch, fail_next, 1'b0};
        fork
            begin
                #(ns);
                wait (!susp);
                if (g == gen && !fail) begin
                    if (!erasing && !prot(tgt)) mem[tgt] = pd;
                    foreach (mem[k]) begin
                        if (erasing && in_sec(18'(k)) && !prot(18'(k))) begin
                            mem[k] = 8'hff;
                        end
                    end
                    busy = 0;
                end
            end
        join_none
    endtask : start

    always @(posedge wcyc) begin
        #1;
        a_lat = addr;
        d_lat = dq_in;
    end

    always @(negedge wcyc) begin
        n_wr++;
        if (d_lat == 8'hf0 && (!busy || fail)) begin
            gen++;
            {busy, fail, auto} = 3'h0;
            step = 0;
        end else if (busy && erasing && !chip && d_lat == 8'hb0) begin
            susp = 1;
        end else if (susp && d_lat == 8'h30) begin
            susp = 0;
        end else if (!busy) begin
            // Only the low twelve address bits qualify command cycles.
            case (step)
                // Suspend and resume sent while the flash is not busy fall out here.
                0, 3: step = a_lat[11:0] == 12'h555 && d_lat == 8'haa ?
                    step + 1 : 0;
                1, 4: step = a_lat[11:0] == 12'h2aa && d_lat == 8'h55 ?
                    step + 1 : 0;
                2: begin
                    auto = d_lat == 8'h90;
                    step = d_lat == 8'ha0 ? 6 : (d_lat == 8'h80 ? 3 : 0);
                end
                6: begin
                    step = 0;
                    tgt = a_lat;
                    pd = d_lat;
                    start(0, 0, prot(a_lat) ? 2000 : PROG_NS);
                end
                default: begin
                    step = 0;
                    tgt = a_lat;
                    if (d_lat == 8'h10) start(1, 1, ERASE_NS);
                    if (d_lat == 8'h30) start(1, 0,
                        prot(a_lat) ? 100000 : ERASE_NS);
                end
            endcase
        end
    end

    assign dq_en = rcyc;
    always @* begin
        if (auto) dq_out = addr[7:0] == 8'h02 ?
            {7'h00, prot(addr)} : ID_CODE;
        else if (!busy) dq_out = rd(addr);
        else if (erasing) dq_out = {susp, tg1, fail, 2'b01, tg2,
            2'b00};
        else dq_out = {~pd[7], tg1, fail, 5'h00};
    end

    always @(negedge rcyc) begin
        if (busy && !susp) tg1 = ~tg1;
        if (busy && erasing && in_sec(addr)) tg2 = ~tg2;
        if (busy && !(erasing ? in_sec(addr) : addr == tgt)) bad_poll++;
    end
endmodule : fwsr_flash_model

// *** tb.sv ***
// Purpose: Self-checking bench for the flash status polling host.
// Assumes: The flash model protects sector 1 only.
// Notes: Each operation is started and polled over Wishbone.
`timescale 1ns/100ps
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] adr = '0;
    logic [3:0] sel = 4'hf;
    logic [3:0] sel_next = 4'hf;
    logic [31:0] wdat = '0;
    logic we = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic ack, ce_n, oe_n, we_n, dq_oe, m_en;
    logic [31:0] rdat, st, dat;
    logic [17:0] fa;
    logic [7:0] dq_o, m_q, dq;
    logic [7:0] last_v = 8'h00;
    int err_count, n_compared;
    // An undriven bus shows a value that changes every cycle.
    assign dq = dq_oe === 1'b1 ? dq_o : (m_en === 1'b1 ? m_q : ~last_v);
    always @(posedge clk) last_v <= dq;

    fwsr_host i_dut (.clk(clk), .rst_n(rst_n), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(sel),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .flash_ce_n(ce_n),
        .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_addr(fa),
        .flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_dq_i(dq));
    fwsr_flash_model m (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(fa),
        .dq_in(dq), .dq_out(m_q), .dq_en(m_en));

    initial begin
        forever #50 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [7:0] e, g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [3:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        adr <= 32'(a);
        sel <= sel_next;
        wdat <= d;
        we <= w;
        cyc <= 1'b1;
        stb <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 50) chk("ack", 8'h1, 8'h0);
    endtask : wb

    // A result of 3 means the outcome code is not checked.
    task automatic run_op(input fwsr_pkg::fwsr_op_t op,
        input logic [17:0] a, input logic [7:0] d, input logic [1:0] res);
        int n;
        n = 0;
        wb(1'b1, fwsr_pkg::REG_ADDR, 32'(a), st);
        wb(1'b1, fwsr_pkg::REG_DATA, 32'(d), st);
        wb(1'b1, fwsr_pkg::REG_CTRL, 32'(op), st);
        wb(1'b1, fwsr_pkg::REG_ADDR, 32'h0, st);
        do begin
            wb(1'b0, fwsr_pkg::REG_STATUS, 32'h0, st);
            n++;
        end while (st[0] !== 1'b0 && n < 5000);
        if (n >= 5000) chk("busy", 8'h00, 8'h01);
        if (res != 2'h3) chk("result", 8'(res), 8'(st[2:1]));
        wb(1'b0, fwsr_pkg::REG_DATA, 32'h0, dat);
    endtask : run_op

    task automatic give_verdict();
        $display("compared %0d errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict

    initial begin
        #2000000;
        err_count++;
        give_verdict();
    end

    initial begin
        int n;
        m.mem[18'h00100] = 8'h3c;
        m.mem[18'h04000] = 8'h11;
        m.mem[18'h02020] = 8'h77;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        wb(1'b0, fwsr_pkg::REG_STATUS, 32'h0, st);
        chk("status", 8'h00, st[7:0]);
        wb(1'b0, 4'h2, 32'h0, st);
        chk("unmapped", 8'h00, st[7:0]);
        n = m.n_wr;
        run_op(fwsr_pkg::FWSR_OP_READ, 18'h00100, 8'h00, 2'h3);
        chk("array", 8'h3c, dat[7:0]);
        chk("no_cmd", 8'(n), 8'(m.n_wr));
        run_op(fwsr_pkg::FWSR_OP_PROGRAM, 18'h00200, 8'h81,
            fwsr_pkg::FWSR_RES_OK);
        chk("prog", 8'h81, m.rd(18'h00200));
        chk("data", 8'h81, dat[7:0]);
        chk("poll_byte", 8'h81, st[10:3]);
        run_op(fwsr_pkg::FWSR_OP_PROGRAM, 18'h02010, 8'h00,
            fwsr_pkg::FWSR_RES_OK);
        chk("prot_prog", 8'hff, m.rd(18'h02010));
        run_op(fwsr_pkg::FWSR_OP_SECTOR_ERASE, 18'h00200, 8'h00,
            fwsr_pkg::FWSR_RES_OK);
        chk("erased", 8'hff, m.rd(18'h00100));
        chk("other_sec", 8'h11, m.rd(18'h04000));
        run_op(fwsr_pkg::FWSR_OP_SECTOR_ERASE, 18'h02000, 8'h00,
            fwsr_pkg::FWSR_RES_OK);
        chk("prot_erase", 8'h77, m.rd(18'h02020));
        run_op(fwsr_pkg::FWSR_OP_CHIP_ERASE, 18'h04000, 8'h00,
            fwsr_pkg::FWSR_RES_OK);
        chk("chip", 8'hff, m.rd(18'h04000));
        chk("chip_prot", 8'h77, m.rd(18'h02020));
        run_op(fwsr_pkg::FWSR_OP_AUTOSELECT, 18'h02002, 8'h00, 2'h3);
        chk("prot_yes", 8'h01, dat[7:0]);
        run_op(fwsr_pkg::FWSR_OP_AUTOSELECT, 18'h04002, 8'h00, 2'h3);
        chk("prot_no", 8'h00, dat[7:0]);
        run_op(fwsr_pkg::FWSR_OP_RESET, 18'h00000, 8'h00, 2'h3);
        chk("auto_left", 8'h00, 8'(m.auto));
        run_op(fwsr_pkg::FWSR_OP_SUSPEND, 18'h00000, 8'h00, 2'h3);
        run_op(fwsr_pkg::FWSR_OP_RESUME, 18'h00000, 8'h00, 2'h3);
        chk("idle", 8'h00, 8'(m.busy));
        run_op(fwsr_pkg::FWSR_OP_READ, 18'h02020, 8'h00, 2'h3);
        chk("array2", 8'h77, dat[7:0]);
        m.fail_next = 1'b1;
        run_op(fwsr_pkg::FWSR_OP_PROGRAM, 18'h06000, 8'h5a,
            fwsr_pkg::FWSR_RES_FAIL);
        chk("fail_reset", 8'h00, 8'(m.busy));
        chk("bad_poll", 8'h00, 8'(m.bad_poll));
        sel_next = 4'he;
        wb(1'b1, fwsr_pkg::REG_ADDR, 32'h3ffff, st);
        sel_next = 4'hf;
        wb(1'b0, fwsr_pkg::REG_ADDR, 32'h0, st);
        chk("sel_lane", 8'h18, st[17:10]);
        give_verdict();
    end
endmodule : tb
